// ### common/sadc_pkg.sv
/*
  Package for the sampling converter bus interface: widths, timing figures
  and derived cycle counts, state encodings, and the list of behaviours.
  Assumes a single 10 MHz system clock.
*/
// Behaviour
// - Full 14-bit result presented as one parallel active-high word.
// - Done flag goes low at conversion start, high when finished.
// - Done flag driven only while its active-low enable is low.
// - Falling output-drive enable starts driving the result bits.
// - Done flag and result outputs are three-state and can release their lines; hold is always driven.
// - Active-low unit select takes part in gating the result bits.
// - Convert start is active low; a falling edge requests conversion.
// - Sample captured a fixed short delay after convert-start falls.
// - Offset strapped to ground gives binary; to reference gives twos complement.
// - Bipolar codes wrap all-ones to all-zeros across midscale.
// - Conversion starts on convert start regardless of unit select.
// - Result bits driven only when select and output enable both low.
package sadc_pkg;
  // ---------------------------------------------------------------
  // Widths and clock
  // ---------------------------------------------------------------
  localparam int RES_W = 14;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int APERTURE_NS = 5;      // Least delay to the sampling instant
  localparam int CONV_TIME_NS = 6300;  // Longest conversion time
  localparam int APERTURE_CYC = (APERTURE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
                                (APERTURE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_NS < 1 ? 1 : CONV_TIME_NS / CLK_NS;
  localparam int CNT_W = 8;

  // ---------------------------------------------------------------
  // Coding
  // ---------------------------------------------------------------
  localparam logic [RES_W-1:0] MSB_MASK = 14'h2000;

  // ---------------------------------------------------------------
  // Conversion sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_APER = 4'h2,
    ST_CONV = 4'h4,
    ST_WAIT = 4'h8
  } sadc_state_t;
endpackage : sadc_pkg

// ### common/sadc_word_if.sv
/*
  Word hand-off carrier between the sequencer and the result buffer.
  Assumes producer and consumer on the same clock.
*/
interface sadc_word_if #(parameter int W = 14);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sadc_word_if

// ### rtl/sadc_sync.sv
/*
  Two flip-flop synchroniser for a bundle of pin levels.
  Assumes pins are asynchronous to sys_clk; reset value is a parameter.
*/
module sadc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Two stages; the first is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sadc_sync

// ### rtl/sadc_buf.sv
/*
  Two-entry result buffer with valid and ready on both sides.
  Assumes one clock; the drain side may stall and the fill side sees it.
*/
module sadc_buf #(
  parameter int W = 14,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill and drain sides
  sadc_word_if.snk in_w,
  sadc_word_if.src out_w
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  // Handshake terms and honest flags
  assign in_w.ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_w.valid = (cnt_reg != '0);
  assign out_w.data = mem[rd_reg];
  assign push = in_w.valid && in_w.ready;
  assign pop = out_w.valid && out_w.ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_w.data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + PW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + PW'(1);
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : sadc_buf

// ### rtl/sadc_top.sv
/*
  Digital bus interface of a 14-bit sampling converter: start strobe,
  three-state done flag, three-state parallel result, output coding.
  Assumes the analog core supplies a sample word in straight binary at
  the sampling instant; all pins are asynchronous and are synchronised.
*/
module sadc_top #(
  parameter int RES_W = sadc_pkg::RES_W,
  parameter int CONV_CYC = sadc_pkg::CONV_CYC,
  parameter int APERTURE_CYC = sadc_pkg::APERTURE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host control pins
  input wire logic convert_start_n,
  input wire logic unit_select_n,
  input wire logic output_enable_n,
  input wire logic done_flag_enable_n,
  // Strap: high when tied to reference output, low at analog ground
  input wire logic polarity_offset_input,
  // Analog core sample, straight binary
  input wire logic [RES_W-1:0] sample_in,
  // Sample-hold control to the analog core
  output logic hold,
  // Done flag pin
  output logic done_flag_o,
  output logic done_flag_oe,
  // Result pins
  output logic [RES_W-1:0] result_bits_o,
  output logic result_bits_oe
);
  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic sc_n_s;
  logic cs_n_s;
  logic oe_n_s;
  logic den_n_s;
  logic bip_s;
  logic [RES_W-1:0] sample_s;

  // Asynchronous assert, synchronous release
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  sadc_sync #(.W(5), .RST_VAL(5'h1f)) u_sync_ctl (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({convert_start_n, unit_select_n, output_enable_n, done_flag_enable_n,
        polarity_offset_input}),
    .q({sc_n_s, cs_n_s, oe_n_s, den_n_s, bip_s})
  );

  sadc_sync #(.W(RES_W)) u_sync_smp (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(sample_in),
    .q(sample_s)
  );

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  logic sc_n_d_reg;
  logic oe_n_d_reg;
  logic sc_fall;
  logic oe_fall;

  // Previous levels of the synchronised strobes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_n_d_reg <= 1'b1;
      oe_n_d_reg <= 1'b1;
    end else begin
      sc_n_d_reg <= sc_n_s;
      oe_n_d_reg <= oe_n_s;
    end
  end
  assign sc_fall = sc_n_d_reg && !sc_n_s;
  assign oe_fall = oe_n_d_reg && !oe_n_s;

  // ---------------------------------------------------------------
  // Output coding
  // ---------------------------------------------------------------
  // Straight binary in unipolar mode, MSB flipped for twos complement
  function automatic logic [RES_W-1:0] code_word(input logic [RES_W-1:0] raw,
                                                 input logic bipolar);
    code_word = bipolar ? (raw ^ RES_W'(sadc_pkg::MSB_MASK)) : raw;
  endfunction : code_word

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  sadc_pkg::sadc_state_t state_reg;
  logic [sadc_pkg::CNT_W-1:0] cnt_reg;
  logic [RES_W-1:0] held_reg;
  logic [RES_W-1:0] out_word_reg;
  logic hold_reg;
  logic done_reg;
  logic last_cyc;

  sadc_word_if #(.W(RES_W)) w_in ();
  sadc_word_if #(.W(RES_W)) w_out ();

  assign last_cyc = (cnt_reg == sadc_pkg::CNT_W'(1));

  // State: start on convert-start edge, regardless of unit select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sadc_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        sadc_pkg::ST_IDLE: begin
          if (sc_fall) begin
            state_reg <= sadc_pkg::ST_APER;
          end
        end
        sadc_pkg::ST_APER: begin
          if (last_cyc) begin
            state_reg <= sadc_pkg::ST_CONV;
          end
        end
        sadc_pkg::ST_CONV: begin
          if (last_cyc) begin
            state_reg <= sadc_pkg::ST_WAIT;
          end
        end
        sadc_pkg::ST_WAIT: begin
          if (w_in.ready) begin
            state_reg <= sadc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Phase counter for aperture and conversion time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (state_reg == sadc_pkg::ST_IDLE && sc_fall) begin
      cnt_reg <= sadc_pkg::CNT_W'(APERTURE_CYC);
    end else if (state_reg == sadc_pkg::ST_APER && last_cyc) begin
      cnt_reg <= sadc_pkg::CNT_W'(CONV_CYC);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - sadc_pkg::CNT_W'(1);
    end
  end

  // Capture sample at the aperture instant; hold released afterwards
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_reg <= '0;
      hold_reg <= 1'b0;
    end else begin
      if (state_reg == sadc_pkg::ST_APER && last_cyc) begin
        held_reg <= sample_s;
      end
      hold_reg <= (state_reg == sadc_pkg::ST_IDLE) ? sc_fall :
                  (state_reg == sadc_pkg::ST_APER);
    end
  end

  // Finished word enters the buffer; a stalled buffer holds the sequencer
  assign w_in.valid = (state_reg == sadc_pkg::ST_WAIT);
  assign w_in.data = code_word(held_reg, bip_s);

  sadc_buf #(.W(RES_W), .DEPTH(2)) u_buf (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_w(w_in.snk),
    .out_w(w_out.src)
  );

  // Host consumes a word at each falling output enable while selected
  assign w_out.ready = oe_fall && !cs_n_s;

  // Output word register, loaded at the start of each read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_word_reg <= '0;
    end else if (w_out.ready && w_out.valid) begin
      out_word_reg <= w_out.data;
    end
  end

  // Done flag: low from start until the word is stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b1;
    end else if (state_reg == sadc_pkg::ST_IDLE && sc_fall) begin
      done_reg <= 1'b0;
    end else if (state_reg == sadc_pkg::ST_WAIT && w_in.ready) begin
      done_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers: three-state done flag and result, hold always driven
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_flag_o <= 1'b1;
      done_flag_oe <= 1'b0;
      result_bits_o <= '0;
      result_bits_oe <= 1'b0;
      hold <= 1'b0;
    end else begin
      done_flag_o <= done_reg;
      done_flag_oe <= !den_n_s;
      result_bits_o <= (w_out.ready && w_out.valid) ? w_out.data : out_word_reg;
      result_bits_oe <= !cs_n_s && !oe_n_s;
      hold <= hold_reg;
    end
  end
endmodule : sadc_top

// ### test/sadc_top_asserts.sv
/*
  Checker on the converter top ports: start, done flag and result gating.
  Assumes it is bound to sadc_top and given the same count parameters.
*/
module sadc_top_asserts #(
  parameter int RES_W = 14,
  parameter int CONV_CYC = 63,
  parameter int APERTURE_CYC = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host pins
  input wire logic convert_start_n,
  input wire logic unit_select_n,
  input wire logic output_enable_n,
  input wire logic done_flag_enable_n,
  // Converter outputs
  input wire logic hold,
  input wire logic done_flag_o,
  input wire logic done_flag_oe,
  input wire logic [RES_W-1:0] result_bits_o,
  input wire logic result_bits_oe
);
  localparam int DLO = APERTURE_CYC + CONV_CYC;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Start pulse seen while idle pulls the flag low within sync delay
  property p_start;
    $fell(convert_start_n) && done_flag_o |-> ##[1:5] !done_flag_o;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
  // Flag is still low aperture plus conversion cycles after it falls, with hold high at the fall
  property p_done_len;
    $fell(done_flag_o) |-> hold ##DLO !done_flag_o;
  endproperty
  a_done_len: assert property (p_done_len) else $error("flag short");
  // Hold drops again soon after the sampling instant
  property p_hold;
    $rose(hold) |-> !done_flag_o ##[1:3] !hold;
  endproperty
  a_hold: assert property (p_hold) else $error("hold stuck");
  // Flag pin driven only while its enable is low
  property p_flag_on;
    !done_flag_enable_n [*8] |-> done_flag_oe;
  endproperty
  a_flag_on: assert property (p_flag_on) else $error("flag not driven");
  property p_flag_off;
    done_flag_enable_n [*8] |-> !done_flag_oe;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag not released");
  // Falling output enable with select low drives the bits
  property p_bits_on;
    $fell(output_enable_n) && !unit_select_n |-> ##3 result_bits_oe;
  endproperty
  a_bits_on: assert property (p_bits_on) else $error("bits not driven");
  property p_bits_off;
    (unit_select_n || output_enable_n) [*4] |-> !result_bits_oe;
  endproperty
  a_bits_off: assert property (p_bits_off) else $error("bits not released");
  // Drive starts only from both pins low and the word holds meanwhile
  property p_bits_cause;
    $rose(result_bits_oe) |-> !$past(unit_select_n, 3) && !$past(output_enable_n, 3);
  endproperty
  a_bits_cause: assert property (p_bits_cause) else $error("bits without select");
  property p_bits_hold;
    result_bits_oe && $past(result_bits_oe) |-> $stable(result_bits_o);
  endproperty
  a_bits_hold: assert property (p_bits_hold) else $error("word changed");
  c_conv: cover property ($fell(done_flag_o));
  c_read: cover property ($rose(result_bits_oe));
  c_flag_off: cover property (done_flag_enable_n && !done_flag_oe);
endmodule : sadc_top_asserts

bind sadc_top sadc_top_asserts #(
  .RES_W(RES_W), .CONV_CYC(CONV_CYC), .APERTURE_CYC(APERTURE_CYC)
) u_chk (
  .sys_clk, .nrst, .convert_start_n, .unit_select_n, .output_enable_n,
  .done_flag_enable_n, .hold, .done_flag_o, .done_flag_oe, .result_bits_o, .result_bits_oe
);

// ### test/sadc_host.sv
/*
  Host model: pulses the start pin and reads one word per enable fall.
  Assumes the caller waits for the done flag before reading.
*/
module sadc_host (
  // Clock
  input wire logic sys_clk,
  // Pins toward the converter
  output logic convert_start_n,
  output logic unit_select_n,
  output logic output_enable_n,
  output logic done_flag_enable_n
);
  // Idle pin levels
  initial begin
    convert_start_n = 1'b1;
    unit_select_n = 1'b1;
    output_enable_n = 1'b1;
    done_flag_enable_n = 1'b0;
  end
  // Short low pulse per conversion, never held low
  task automatic start(input logic cs_n);
    @(posedge sys_clk);
    unit_select_n <= cs_n;
    convert_start_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    convert_start_n <= 1'b1;
    unit_select_n <= 1'b1;
  endtask : start
  // Select, lower enable, release, then keep the gap before any start
  task automatic read(input logic cs_n);
    @(posedge sys_clk);
    unit_select_n <= cs_n;
    @(posedge sys_clk);
    output_enable_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    output_enable_n <= 1'b1;
    unit_select_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask : read
endmodule : sadc_host

// ### test/sadc_top_bench.sv
/*
  Self-checking bench for the converter top with a host model.
  Assumes a shortened conversion count; expected words go through a queue.
*/
module sadc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, polarity_offset_input, hold, done_flag_o, done_flag_oe;
  logic convert_start_n, unit_select_n, output_enable_n, done_flag_enable_n;
  logic result_bits_oe, oe_q;
  logic [sadc_pkg::RES_W-1:0] sample_in, result_bits_o;
  logic [sadc_pkg::RES_W-1:0] exp_q[$];
  logic [31:0] seed = 32'hc8ad;
  int miscompares, n_tests;

  sadc_host u_host (.sys_clk, .convert_start_n, .unit_select_n, .output_enable_n,
    .done_flag_enable_n);
  sadc_top #(.CONV_CYC(4), .APERTURE_CYC(1)) u_dut (.sys_clk, .nrst, .convert_start_n,
    .unit_select_n, .output_enable_n, .done_flag_enable_n, .polarity_offset_input,
    .sample_in, .hold, .done_flag_o, .done_flag_oe, .result_bits_o, .result_bits_oe);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic complete_run();
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [13:0] e, input logic [13:0] a);
    n_tests++;
    if (a !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, a);
    end
  endtask : chk
  // Bounded wait for a driven, high done flag
  task automatic wait_idle();
    for (int k = 0; k < 200 && !(done_flag_oe === 1'b1 && done_flag_o === 1'b1); k++)
      @(posedge sys_clk);
    chk("done_flag_o", 14'h1, {13'h0, done_flag_o});
  endtask : wait_idle
  // One conversion; the expected coded word is noted for the monitor
  task automatic conv(input logic [13:0] s, input logic cs_n);
    @(posedge sys_clk);
    sample_in <= s;
    exp_q.push_back(polarity_offset_input ? s ^ 14'h2000 : s);
    u_host.start(cs_n);
    repeat (4) @(posedge sys_clk);
    chk("done_flag_o", 14'h0, {13'h0, done_flag_o});
  endtask : conv

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Result monitor: each new drive of the bits takes the oldest note
  always @(posedge sys_clk) begin
    oe_q <= result_bits_oe;
    if (result_bits_oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) chk("result_count", 14'h0, 14'h1);
      else chk("result_bits_o", exp_q.pop_front(), result_bits_o);
    end
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
  // Main sequence
  initial begin
    logic [13:0] tbl [4] = '{14'h1fff, 14'h2000, 14'h0000, 14'h3fff};
    nrst = 1'b0;
    oe_q = 1'b0;
    polarity_offset_input = 1'b0;
    sample_in = '0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Both codings over midscale edges, extremes and random words
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      polarity_offset_input <= i[0];
      conv(i < 8 ? tbl[i[2:1]] : seed[13:0], i[1]);
      wait_idle();
      u_host.read(1'b0);
    end
    // Fill the buffer; the third word waits with the flag low
    polarity_offset_input <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      conv(seed[13:0], 1'b0);
      if (i < 2) wait_idle();
    end
    repeat (20) @(posedge sys_clk);
    chk("done_flag_o", 14'h0, {13'h0, done_flag_o});
    // Unselected read must leave the bits released
    u_host.read(1'b1);
    repeat (3) u_host.read(1'b0);
    wait_idle();
    // Flag enable high releases the flag pin
    u_host.done_flag_enable_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("done_flag_oe", 14'h0, {13'h0, done_flag_oe});
    u_host.done_flag_enable_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    complete_run();
  end
endmodule : sadc_top_bench
